// >>> hdl/sram_cycle_pkg.sv
// Constants shared by the synchronous flow-through SRAM cycle controller.
// Assumes a single rising-edge clock and a host that drives the bus
// synchronously with it.
//
// Notes on behaviour
// - Selected only when enable1 low, enable2 high, enable3 low
// - Full write: global write low, or gate plus all lanes low
// - Data floats after write until strobed read
// - Data lines float on leaving sleep mode
package sram_cycle_pkg;
    localparam int ADDR_W = 19;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam logic [LANES-1:0] LANES_ALL_LOW = 4'h0;
    localparam logic [LANES-1:0] LANES_ALL_HIGH = 4'hf;
endpackage

// >>> hdl/sram_cycle_ctrl.sv
// Cycle-level core of a synchronous flow-through SRAM: chip select,
// write start, data bus turn-around and sleep entry and exit.
// Assumes all synchronous inputs are launched on I_REF_CLK; output
// enable and sleep request arrive from pins and are synchronised here.
`timescale 1ns/1ps
module sram_cycle_ctrl
    import sram_cycle_pkg::*;
#(
    parameter int AW = ADDR_W
)
(
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST_B,
    // Chip enables
    input wire logic I_CHIP_EN1_N,
    input wire logic I_CHIP_EN2,
    input wire logic I_CHIP_EN3_N,
    // Address strobes and address
    input wire logic I_PROCESSOR_ADDR_STROBE_N,
    input wire logic I_CONTROLLER_ADDR_STROBE_N,
    input wire logic [AW-1:0] I_ADDR,
    // Write controls
    input wire logic I_GLOBAL_WRITE_N,
    input wire logic I_BYTE_WRITE_GATE_N,
    input wire logic [LANES-1:0] I_BYTE_LANE_WRITE_N,
    // Asynchronous pins
    input wire logic I_OUTPUT_EN_N,
    input wire logic I_SLEEP_REQUEST,
    // Data bus, three signals per two-way pin
    input wire logic [DATA_W-1:0] I_DQ,
    output logic [DATA_W-1:0] O_DQ,
    output logic O_DQ_OE_N,
    // Status
    output logic O_SELECTED,
    output logic O_SLEEPING
);

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_SLEEP} phase_t;

    typedef struct packed {
        phase_t phase;
        logic [DATA_W-1:0] rdata;
        logic oe_s1;
        logic oe_s2;
        logic zz_s1;
        logic zz_s2;
        logic sel;
    } state_t;

    // All sequential state but the memory array lives in one struct; the two synchroniser pairs
    // ride along so that reset reaches them together with the phase.
    state_t state_reg;
    state_t state_next;
    // Storage follows the address parameter, not the package default,
    // so a narrower instance does not carry an oversized array.
    logic [DATA_W-1:0] mem [1 << AW];
    logic selected;
    logic strobe;
    logic full_write;
    logic [LANES-1:0] lane_we;

    // Select decode, used for both strobe qualification and status
    function automatic logic chip_select(input logic e1_n, input logic e2, input logic e3_n);
        return !e1_n && e2 && !e3_n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Cycle decode
    always_comb
    begin
        selected = chip_select(I_CHIP_EN1_N, I_CHIP_EN2, I_CHIP_EN3_N);
        strobe = !I_PROCESSOR_ADDR_STROBE_N || !I_CONTROLLER_ADDR_STROBE_N;
        // Full width write either way; gate with some lanes gives partial
        full_write = !I_GLOBAL_WRITE_N ||
            (!I_BYTE_WRITE_GATE_N && I_BYTE_LANE_WRITE_N == LANES_ALL_LOW);
        if (!I_GLOBAL_WRITE_N)
            lane_we = LANES_ALL_HIGH;
        else if (!I_BYTE_WRITE_GATE_N)
            lane_we = ~I_BYTE_LANE_WRITE_N;
        else
            lane_we = LANES_ALL_LOW;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state; processor strobe never starts a write (it is a read start)
    always_comb
    begin
        state_next = state_reg;
        state_next.oe_s1 = I_OUTPUT_EN_N;
        state_next.oe_s2 = state_reg.oe_s1;
        state_next.zz_s1 = I_SLEEP_REQUEST;
        state_next.zz_s2 = state_reg.zz_s1;
        if (state_reg.zz_s2)
        begin
            // Host deselects first; entry still forced so sleep is honoured
            state_next.phase = ST_SLEEP;
            state_next.sel = 1'b0;
        end
        else if (state_reg.phase == ST_SLEEP)
            state_next.phase = ST_IDLE;
        else if (strobe)
        begin
            state_next.sel = selected;
            if (!selected)
                state_next.phase = ST_IDLE;
            else if (I_PROCESSOR_ADDR_STROBE_N && (lane_we != LANES_ALL_LOW))
                state_next.phase = ST_WRITE;
            else
            begin
                state_next.phase = ST_READ;
                state_next.rdata = mem[I_ADDR];
            end
        end
        else if (state_reg.phase == ST_WRITE && lane_we == LANES_ALL_LOW)
            state_next.phase = ST_WRITE;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; memory array has no reset by design
    always_ff @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            state_reg <= '{phase: ST_IDLE, rdata: '0, oe_s1: 1'b1, oe_s2: 1'b1,
                           zz_s1: 1'b0, zz_s2: 1'b0, sel: 1'b0};
        else
            state_reg <= state_next;
    end

    // Memory write on the strobe edge; lanes not enabled keep their old value.
    // No reset here: clearing a large array would cost far more than it gains.
    always_ff @(posedge I_REF_CLK)
    begin
        if (strobe && selected && I_PROCESSOR_ADDR_STROBE_N && !state_reg.zz_s2)
        begin
            for (int l = 0; l < LANES; l++)
            begin
                if (lane_we[l])
                    mem[I_ADDR][l*LANE_W +: LANE_W] <= I_DQ[l*LANE_W +: LANE_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; the bus only drives in a read phase with enable low
    assign O_DQ = state_reg.rdata;
    assign O_DQ_OE_N = !(state_reg.phase == ST_READ && !state_reg.oe_s2);
    assign O_SELECTED = state_reg.sel;
    assign O_SLEEPING = (state_reg.phase == ST_SLEEP);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sel_decode_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (strobe && !state_reg.zz_s2) |=> (O_SELECTED ==
            $past(!I_CHIP_EN1_N && I_CHIP_EN2 && !I_CHIP_EN3_N)))
        else $error("select decode wrong");
    full_write_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        full_write |-> (lane_we == LANES_ALL_HIGH))
        else $error("full write not all lanes");
    write_float_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (state_reg.phase == ST_WRITE && !strobe) |=> O_DQ_OE_N)
        else $error("bus driven after write");
    sleep_entry_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        state_reg.zz_s2 |=> (O_SLEEPING && !O_SELECTED))
        else $error("sleep not entered");
    sleep_exit_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (O_SLEEPING && !state_reg.zz_s2) |=> (O_DQ_OE_N && !O_SLEEPING))
        else $error("bus driven on sleep exit");
    read_drive_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        !O_DQ_OE_N |-> (state_reg.phase == ST_READ && !state_reg.oe_s2))
        else $error("bus driven outside read");
    oe_float_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        I_OUTPUT_EN_N [*3] |-> O_DQ_OE_N)
        else $error("bus driven with enable high");
    read_start_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (!I_PROCESSOR_ADDR_STROBE_N && selected && !state_reg.zz_s2 && !state_reg.oe_s1)
            |=> !O_DQ_OE_N)
        else $error("strobed read not driven");

    // Write and read starts; the phase must follow the strobe one edge later
    write_start_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (strobe && selected && I_PROCESSOR_ADDR_STROBE_N && !state_reg.zz_s2 && full_write)
            |=> (state_reg.phase == ST_WRITE))
        else $error("full write not started");
    partial_write_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (strobe && selected && I_PROCESSOR_ADDR_STROBE_N && !state_reg.zz_s2 && !full_write
            && lane_we != LANES_ALL_LOW) |=> (state_reg.phase == ST_WRITE))
        else $error("lane write not started");
    proc_read_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (!I_PROCESSOR_ADDR_STROBE_N && selected && !state_reg.zz_s2)
            |=> (state_reg.phase == ST_READ))
        else $error("processor strobe did not read");

    // A deselect or sleep must leave the bus floating, else two parts fight
    deselect_float_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (strobe && !selected && !state_reg.zz_s2) |=> (O_DQ_OE_N && !O_SELECTED))
        else $error("bus driven when deselected");
    sleep_float_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        O_SLEEPING |-> (O_DQ_OE_N && !O_SELECTED))
        else $error("bus driven in sleep");

    // Read data holds between strobes so a slow host still sees it
    read_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (state_reg.phase == ST_READ && !strobe && !state_reg.zz_s2) |=> $stable(O_DQ))
        else $error("read data changed without strobe");

    read_seen_c: cover property (@(posedge I_REF_CLK) !O_DQ_OE_N);
    write_seen_c: cover property (@(posedge I_REF_CLK) state_reg.phase == ST_WRITE);
    turn_c: cover property (@(posedge I_REF_CLK)
        state_reg.phase == ST_WRITE ##1 state_reg.phase == ST_READ);
    sleep_c: cover property (@(posedge I_REF_CLK) O_SLEEPING ##1 !O_SLEEPING);
    deselect_c: cover property (@(posedge I_REF_CLK)
        strobe && !selected && !state_reg.zz_s2);

endmodule

// >>> tb/sram_host_model.sv
// Host side of the shared data bus: resolves the two-way data lines.
// Assumes the device enable is low while the device drives the lines.
`timescale 1ns/1ps
module sram_host_model
    import sram_cycle_pkg::*;
(
    // Host side
    input wire logic i_host_oe_n,
    input wire logic [DATA_W-1:0] i_host_data,
    // Device side
    input wire logic i_dev_oe_n,
    input wire logic [DATA_W-1:0] i_dev_data,
    output logic [DATA_W-1:0] o_bus
);
    // Floating bus shows the inverse of the host data, so a stale value never matches
    always_comb
    begin
        if (!i_host_oe_n)
            o_bus = i_host_data;
        else if (!i_dev_oe_n)
            o_bus = i_dev_data;
        else
            o_bus = ~i_host_data;
    end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the SRAM cycle controller.
// Assumes the host model resolves the data lines.
`timescale 1ns/1ps
module tb_top
    import sram_cycle_pkg::*;
;
    logic clk = 0, rst_b = 0, en1_n = 0, en2 = 1, en3_n = 0, ps_n = 1, cs_n = 1;
    logic gw_n = 1, gate_n = 1, oe_n = 0, slp = 0, host_oe_n = 1, dq_oe_n, sel, sleeping;
    logic [3:0] lanes_n = 4'hf;
    logic [18:0] addr = '0;
    logic [35:0] hdata = '0, bus, dq;
    int failures = 0, n_tests = 0;
    sram_cycle_ctrl u_sram_cycle_ctrl (.I_REF_CLK(clk), .I_RST_B(rst_b),
        .I_CHIP_EN1_N(en1_n), .I_CHIP_EN2(en2), .I_CHIP_EN3_N(en3_n),
        .I_PROCESSOR_ADDR_STROBE_N(ps_n), .I_CONTROLLER_ADDR_STROBE_N(cs_n), .I_ADDR(addr),
        .I_GLOBAL_WRITE_N(gw_n), .I_BYTE_WRITE_GATE_N(gate_n), .I_BYTE_LANE_WRITE_N(lanes_n),
        .I_OUTPUT_EN_N(oe_n), .I_SLEEP_REQUEST(slp), .I_DQ(bus), .O_DQ(dq),
        .O_DQ_OE_N(dq_oe_n), .O_SELECTED(sel), .O_SLEEPING(sleeping));
    sram_host_model u_sram_host_model (.i_host_oe_n(host_oe_n), .i_host_data(hdata),
        .i_dev_oe_n(dq_oe_n), .i_dev_data(dq), .o_bus(bus));
    ////////////////////////////////////////////////////////////////
    // Free-running 250 MHz clock
    initial forever #2 clk = ~clk;
    task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One strobed cycle; host drives data for every controller-strobe cycle, read or write
    task automatic cyc(input logic p, input logic c, input logic g, input logic [18:0] a,
        input logic [35:0] d);
        ps_n = p; cs_n = c; gw_n = g; addr = a; hdata = d; host_oe_n = !(p && !c);
        @(posedge clk);
        #1;
        ps_n = 1; cs_n = 1; gw_n = 1; host_oe_n = 1;
    endtask
    task automatic rd_chk(input logic c, input logic [18:0] a, input logic [35:0] d);
        cyc(!c, c, 1, a, 36'h0);
        @(posedge clk);
        #1;
        chk("read data", d, bus);
        chk("read drive", 1'b0, dq_oe_n);
        chk("selected", 1'b1, sel);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_global_write;
        cyc(1, 0, 0, 19'h12345, 36'h9abcdef01);
        chk("float after write", 1'b1, dq_oe_n);
        rd_chk(0, 19'h12345, 36'h9abcdef01);
        $display("global write done");
    endtask
    task automatic t_gate_write;
        gate_n = 0; lanes_n = 4'h0;
        cyc(1, 0, 1, 19'h00abc, 36'h123456789);
        gate_n = 1; lanes_n = 4'hf;
        rd_chk(1, 19'h00abc, 36'h123456789);
        cyc(1, 0, 0, 19'h00abc, 36'h0f0f0f0f0); // Back-to-back write after a driven read
        repeat (3) @(posedge clk);
        #1;
        chk("float held after write", 1'b1, dq_oe_n);
        rd_chk(1, 19'h00abc, 36'h0f0f0f0f0);
        gate_n = 0; lanes_n = 4'he;
        cyc(1, 0, 1, 19'h00abc, 36'h111111111); // Lane 0 only
        gate_n = 1; lanes_n = 4'hf;
        rd_chk(1, 19'h00abc, 36'h0f0f0f111);
        $display("gate write done");
    endtask
    task automatic t_deselect;
        for (int i = 0; i < 3; i++)
        begin
            en1_n = (i == 0); en2 = (i != 1); en3_n = (i == 2);
            cyc(0, 1, 1, 19'h12345, 36'h0);
            @(posedge clk);
            #1;
            chk("deselected", 1'b0, sel);
            chk("deselected float", 1'b1, dq_oe_n);
        end
        en1_n = 0; en2 = 1; en3_n = 0;
        $display("deselect done");
    endtask
    task automatic t_output_enable;
        rd_chk(0, 19'h12345, 36'h9abcdef01);
        oe_n = 1;
        repeat (4) @(posedge clk);
        #1;
        chk("oe high float", 1'b1, dq_oe_n);
        oe_n = 0;
        repeat (3) @(posedge clk);
        $display("output enable done");
    endtask
    task automatic t_sleep;
        rd_chk(0, 19'h12345, 36'h9abcdef01);
        en1_n = 1; // Host deselects with a strobe before sleep
        cyc(0, 1, 1, 19'h0, 36'h0);
        slp = 1;
        repeat (4) @(posedge clk);
        #1;
        chk("sleeping", 1'b1, sleeping);
        slp = 0;
        repeat (4) @(posedge clk);
        #1;
        chk("awake", 1'b0, sleeping);
        chk("float on wake", 1'b1, dq_oe_n);
        en1_n = 0;
        $display("sleep done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Watchdog well beyond the 44 or so cycles the tests need
    initial
    begin
        #20000;
        failures++;
        wrap_up();
    end
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        #1;
        rst_b = 1;
        t_global_write();
        t_gate_write();
        t_deselect();
        t_output_enable();
        t_sleep();
        wrap_up();
    end
endmodule
